// ===== hw/timer_prescaler_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer prescaler.
`ifndef TIMER_PRESCALER_CONSTS_SVH
`define TIMER_PRESCALER_CONSTS_SVH
`define GTC_OFFSET        12'h000
`define CSEL_OFFSET       12'h004
`define STATUS_OFFSET     12'h008
`define GTC_RESET         8'h00
`define CSEL_RESET        8'h00
`define SYNC_HOLD_BIT     7
`define DIV_RESET_BIT     0
`define CSEL1_LSB         4
`define PRESCALER_WIDTH   10
`define EXT_SYNC_STAGES   3
`endif

// ===== hw/timer_prescaler_pkg.sv
// Types shared by the timer prescaler block.
package timer_prescaler_pkg;
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
   } count_source_t;
   typedef logic [1:0] axi_resp_t;
endpackage : timer_prescaler_pkg

// ===== hw/timer_prescaler_sync.sv
// Shared timer prescaler, external count pin conditioning and AXI4-Lite control registers.
// Operating notes.
// The block owns one free-running divider that every timer shares.
// Each timer picks its own count source from the count select register.
// A timer never sees a clock of its own; it sees a one-cycle count pulse.
// The pulse is registered, so a timer counts one cycle after the tap fires.
// Select 1 gives a pulse on every system clock cycle.
// Selects 2 to 5 give a pulse when the divider's low bits are all ones.
// A timer that starts on a tap waits for the divider phase to come round.
// Changing a select never touches the divider, so phases stay aligned.
// Selects 6 and 7 follow the external pin of that timer instead.
// The pin passes two flip-flops before the filter looks at it, and three in all.
// A level is accepted only when the second and third stages agree.
// That filter costs a cycle of latency but drops single-cycle glitches.
// The edge detector compares the accepted level with the last one.
// An accepted edge gives exactly one pulse, on the edge that was selected.
// A pin source is never divided; each accepted edge is one count.
// The pin must stay at least two cycles at each level to be seen at all.
// Software should switch a pin source only while that pin is quiet.
// Otherwise a stale level in the filter can look like a fresh edge.
// The control register holds sync mode in bit 7 and the divider reset in bit 0.
// Writing the divider reset alone clears the divider for one cycle.
// The bit then drops by itself on the next cycle.
// With sync mode set the written divider reset value is kept.
// A held divider reset keeps the divider at zero and blocks every pulse.
// Timers can then be set up with no risk of a stray count.
// Writing sync mode back to zero lets the bit drop and counting resume.
// Reads of the control register show only bits 7 and 0; the rest read zero.
// The status word shows the divider value and the accepted pin levels.
// Only byte lane 0 of a write carries data; other lanes are ignored.
// Unmapped addresses answer with a slave error and change nothing.
// One write and one read may be under way at a time.
// A write answers two cycles after both of its halves have been taken.
// A read answers one cycle after its address has been taken.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`include "timer_prescaler_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_sync #(
   parameter int NUM_TIMERS = 2
) (
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   input  wire logic [11:0]                     s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output var  logic                            s_axi_awready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output var  logic                            s_axi_wready,
   output var  timer_prescaler_pkg::axi_resp_t  s_axi_bresp,
   output var  logic                            s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   input  wire logic [11:0]                     s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output var  logic                            s_axi_arready,
   output var  logic [31:0]                     s_axi_rdata,
   output var  timer_prescaler_pkg::axi_resp_t  s_axi_rresp,
   output var  logic                            s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   input  wire logic [NUM_TIMERS-1:0]           ext_count_pin,
   output var  logic [NUM_TIMERS-1:0]           timer_count_pulse
);
   import timer_prescaler_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register and bus state.
   logic [7:0]  general_timer_control;
   logic [7:0]  next_general_timer_control;
   logic [7:0]  csel_reg;
   logic [7:0]  next_csel_reg;
   logic        aw_held;
   logic        next_aw_held;
   logic [11:0] aw_addr;
   logic [11:0] next_aw_addr;
   logic        w_held;
   logic        next_w_held;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic [3:0]  w_strb;
   logic [3:0]  next_w_strb;
   logic        bvalid_q;
   logic        next_bvalid_q;
   logic [1:0]  bresp_q;
   logic [1:0]  next_bresp_q;
   logic        rvalid_q;
   logic        next_rvalid_q;
   logic [31:0] rdata_q;
   logic [31:0] next_rdata_q;
   logic [1:0]  rresp_q;
   logic [1:0]  next_rresp_q;

   // Prescaler and pin conditioning state.
   logic [`PRESCALER_WIDTH-1:0] prescaler;
   logic [`PRESCALER_WIDTH-1:0] next_prescaler;
   logic [NUM_TIMERS-1:0]       pin_s1;
   logic [NUM_TIMERS-1:0]       pin_s2;
   logic [NUM_TIMERS-1:0]       pin_s3;
   logic [NUM_TIMERS-1:0]       pin_level;
   logic [NUM_TIMERS-1:0]       next_pin_level;
   logic [NUM_TIMERS-1:0]       next_pulse;
   logic                        divider_reset;
   logic [3:0]                  taps;

   logic       do_write;
   logic [7:0] wbyte;

   // A write fires once both address and data have been captured.
   assign do_write = aw_held && w_held && !bvalid_q;
   assign wbyte    = w_data[7:0];

   // Address and data channels are taken independently, one write at a time.
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid_q = bvalid_q;
      next_bresp_q  = bresp_q;
      next_general_timer_control = general_timer_control;
      next_csel_reg = csel_reg;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (!general_timer_control[`SYNC_HOLD_BIT]) begin
         next_general_timer_control[`DIV_RESET_BIT] = 1'b0;
      end
      if (do_write) begin
         next_aw_held  = 1'b0;
         next_w_held   = 1'b0;
         next_bvalid_q = 1'b1;
         next_bresp_q  = RESP_OKAY;
         if ({aw_addr[11:2], 2'b00} == `GTC_OFFSET) begin
            if (w_strb[0]) begin
               next_general_timer_control[`SYNC_HOLD_BIT] = wbyte[`SYNC_HOLD_BIT];
               // clear on exit
               // The written value is kept while sync mode is set; without sync mode
               // the self-clear above drops it again on the following cycle.
               next_general_timer_control[`DIV_RESET_BIT] = wbyte[`DIV_RESET_BIT];
            end
         end else if ({aw_addr[11:2], 2'b00} == `CSEL_OFFSET) begin
            if (w_strb[0]) begin
               next_csel_reg = {1'b0, wbyte[6:4], 1'b0, wbyte[2:0]};
            end
         end else if ({aw_addr[11:2], 2'b00} != `STATUS_OFFSET) begin
            next_bresp_q = RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready) begin
         next_bvalid_q = 1'b0;
      end
   end

   // Read channel: one answer per accepted address.
   always_comb begin
      next_rvalid_q = rvalid_q;
      next_rdata_q  = rdata_q;
      next_rresp_q  = rresp_q;
      if (s_axi_arvalid && !rvalid_q) begin
         next_rvalid_q = 1'b1;
         next_rresp_q  = RESP_OKAY;
         next_rdata_q  = 32'h0000_0000;
         if ({s_axi_araddr[11:2], 2'b00} == `GTC_OFFSET) begin
            next_rdata_q[7:0] = general_timer_control & 8'h81;
         end else if ({s_axi_araddr[11:2], 2'b00} == `CSEL_OFFSET) begin
            next_rdata_q[7:0] = csel_reg;
         end else if ({s_axi_araddr[11:2], 2'b00} == `STATUS_OFFSET) begin
            next_rdata_q[`PRESCALER_WIDTH-1:0] = prescaler;
            next_rdata_q[16+NUM_TIMERS-1:16]   = pin_level;
         end else begin
            next_rresp_q = RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         next_rvalid_q = 1'b0;
      end
   end

   // Divider reset comes from the control bit, held or momentary.
   assign divider_reset = general_timer_control[`DIV_RESET_BIT];

   always_comb begin
      next_prescaler = divider_reset ? '0 : prescaler + 1'b1;
   end

   assign taps[0] = (prescaler[2:0] == 3'h7);
   assign taps[1] = (prescaler[5:0] == 6'h3f);
   assign taps[2] = (prescaler[7:0] == 8'hff);
   assign taps[3] = (prescaler == 10'h3ff);

   // Per-timer pin conditioning and count source selection.
   // shared prescaler
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
         logic [2:0] sel;
         logic       rise;
         logic       fall;
         assign sel = csel_reg[gi*`CSEL1_LSB +: 3];
         assign next_pin_level[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_level[gi];
         assign rise = next_pin_level[gi] && !pin_level[gi];
         assign fall = !next_pin_level[gi] && pin_level[gi];
         always_comb begin
            if (divider_reset) begin
               next_pulse[gi] = 1'b0;
            end else begin
               case (sel)
                  CS_STOP:     next_pulse[gi] = 1'b0;
                  CS_DIV1:     next_pulse[gi] = 1'b1;
                  CS_DIV8:     next_pulse[gi] = taps[0];
                  CS_DIV64:    next_pulse[gi] = taps[1];
                  CS_DIV256:   next_pulse[gi] = taps[2];
                  CS_DIV1024:  next_pulse[gi] = taps[3];
                  CS_EXT_FALL: next_pulse[gi] = fall;
                  CS_EXT_RISE: next_pulse[gi] = rise;
                  default:     next_pulse[gi] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // Write channel and control registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         general_timer_control <= `GTC_RESET;
         csel_reg  <= `CSEL_RESET;
         aw_held   <= 1'b0;
         aw_addr   <= 12'h000;
         w_held    <= 1'b0;
         w_data    <= 32'h0000_0000;
         w_strb    <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         general_timer_control <= next_general_timer_control;
         csel_reg  <= next_csel_reg;
         aw_held   <= next_aw_held;
         aw_addr   <= next_aw_addr;
         w_held    <= next_w_held;
         w_data    <= next_w_data;
         w_strb    <= next_w_strb;
         bvalid_q  <= next_bvalid_q;
         bresp_q   <= next_bresp_q;
      end
   end

   // Read channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else begin
         rvalid_q  <= next_rvalid_q;
         rdata_q   <= next_rdata_q;
         rresp_q   <= next_rresp_q;
      end
   end

   // Shared divider register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescaler <= '0;
      end else begin
         prescaler <= next_prescaler;
      end
   end

   // Pin synchronizer, accepted levels and registered count pulses.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1    <= '0;
         pin_s2    <= '0;
         pin_s3    <= '0;
         pin_level <= '0;
         timer_count_pulse <= '0;
      end else begin
         pin_s1    <= ext_count_pin;
         pin_s2    <= pin_s1;
         pin_s3    <= pin_s2;
         pin_level <= next_pin_level;
         timer_count_pulse <= next_pulse;
      end
   end

   // Ready signals reflect free capture slots; outputs come from flops.
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
endmodule : timer_prescaler_sync
`default_nettype wire

// ===== tb/pulse_tally.sv
// Timer stand-in that counts the count pulses it receives.
`timescale 1ns/1ps
`default_nettype none
module pulse_tally (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        pulse,
   output var  logic [15:0] count
);
   // halts without pulses
   // The count moves only on a pulse, as a real timer would.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 16'h0000;
      end else if (pulse) begin
         count <= count + 16'h0001;
      end
   end
endmodule : pulse_tally
`default_nettype wire

// ===== tb/test_timer_prescaler_sync.sv
// Self-checking bench for the timer prescaler.
`include "timer_prescaler_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_timer_prescaler_sync;
   import timer_prescaler_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   axi_resp_t   s_axi_bresp, s_axi_rresp, rsp;
   logic [1:0]  ext_count_pin, timer_count_pulse;
   logic [15:0] cnt0, cnt1, d0, d1;
   logic [7:0]  sels [3] = '{8'h52, 8'h43, 8'h01};
   logic [15:0] e0 [3] = '{16'h0080, 16'h0010, 16'h0400};
   logic [15:0] e1 [3] = '{16'h0001, 16'h0004, 16'h0000};
   int          n_mismatch = 0, n_checks = 0, cyc = 0;
   timer_prescaler_sync timer_prescaler_sync_inst (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .ext_count_pin, .timer_count_pulse);
   pulse_tally pulse_tally_inst (.aclk, .aresetn, .pulse(timer_count_pulse[0]), .count(cnt0));
   pulse_tally pulse_tally_inst1 (.aclk, .aresetn, .pulse(timer_count_pulse[1]), .count(cnt1));
   // Clock and the hang guard.
   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Write holds each channel until taken and waits for the response.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   // Pulses seen by each timer over n cycles.
   task automatic span(input int n);
      logic [15:0] a0, a1;
      repeat (4) @(posedge aclk);
      #1 a0 = cnt0;
      a1 = cnt1;
      repeat (n) @(posedge aclk);
      #1 d0 = cnt0 - a0;
      d1 = cnt1 - a1;
   endtask : span
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // Main sequence of tests.
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_count_pin} = 58'h0;
      aresetn = 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`GTC_OFFSET);
      chk("control reset", rd_v, 32'h0000_0000);
      rd(12'h00C);
      chk("unmapped read", rsp, 32'h0000_0002);
      wr(12'h00C, 32'h0000_0001);
      chk("unmapped write", rsp, 32'h0000_0002);
      $display("test registers finished");
      for (int i = 0; i < 3; i++) begin
         wr(`CSEL_OFFSET, {24'h00_0000, sels[i]});
         span(1024);
         chk("tap timer0", d0, e0[i]);
         chk("tap timer1", d1, e1[i]);
      end
      $display("test taps finished");
      wr(`GTC_OFFSET, 32'h0000_0081);
      chk("write resp", rsp, 32'h0000_0000);
      rd(`GTC_OFFSET);
      chk("held control", rd_v, 32'h0000_0081);
      wr(`CSEL_OFFSET, 32'h0000_0011);
      span(50);
      chk("held timer0", d0, 32'h0000_0000);
      rd(`STATUS_OFFSET);
      chk("held divider", rd_v & 32'h0000_03FF, 32'h0000_0000);
      wr(`GTC_OFFSET, 32'h0000_0080);
      rd(`GTC_OFFSET);
      chk("hold released", rd_v, 32'h0000_0080);
      span(50);
      chk("resumed timer1", d1, 32'h0000_0032);
      wr(`GTC_OFFSET, 32'h0000_0081);
      wr(`GTC_OFFSET, 32'h0000_0000);
      rd(`GTC_OFFSET);
      chk("sync exit", rd_v, 32'h0000_0000);
      wr(`GTC_OFFSET, 32'h0000_0001);
      rd(`GTC_OFFSET);
      chk("self clear", rd_v, 32'h0000_0000);
      $display("test hold finished");
      // pins stay low while the source is switched
      wr(`CSEL_OFFSET, 32'h0000_0067);
      fork
         span(110);
         repeat (5) begin
            repeat (10) @(posedge aclk);
            ext_count_pin <= 2'h3;
            repeat (10) @(posedge aclk);
            ext_count_pin <= 2'h0;
         end
      join
      chk("rising edges", d0, 32'h0000_0005);
      chk("falling edges", d1, 32'h0000_0005);
      $display("test external finished");
      close_out();
   end
endmodule : test_timer_prescaler_sync
`default_nettype wire

// ===== tb/timer_prescaler_sync_props.sv
// Port assertions for the timer prescaler.
`include "timer_prescaler_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_sync_props #(
   parameter int NUM_TIMERS = 2
) (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic [11:0]           s_axi_awaddr,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic [31:0]           s_axi_wdata,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic [NUM_TIMERS-1:0] ext_count_pin,
   input wire logic [NUM_TIMERS-1:0] timer_count_pulse
);
   logic       wr;
   logic [3:0] quiet;
   logic [2:0] sel0;
   logic [2:0] sel1;
   logic       held;
   logic [1:0] tp;
   // A write lands when address and data are taken together.
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign tp = timer_count_pulse[1:0];
   // Shadow of the selects, a held divider reset and the cycles since a write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quiet <= 4'h0;
         sel0  <= 3'h0;
         sel1  <= 3'h0;
         held  <= 1'h0;
      end else begin
         quiet <= wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
         sel0  <= (wr && s_axi_awaddr == `CSEL_OFFSET) ? s_axi_wdata[2:0] : sel0;
         sel1  <= (wr && s_axi_awaddr == `CSEL_OFFSET) ? s_axi_wdata[6:4] : sel1;
         held  <= (wr && s_axi_awaddr == `GTC_OFFSET) ? s_axi_wdata[7] & s_axi_wdata[0] : held;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_DIV1_EVERY: assert property (quiet > 4'h2 && sel0 == 3'h1 && !held |-> tp[0])
      else $error("select one skipped a cycle");
   AST_STOP_QUIET: assert property (quiet > 4'h2 && sel0 == 3'h0 |-> !tp[0])
      else $error("stopped timer got a pulse");
   AST_SEL_APART: assert property (quiet > 4'h2 && sel1 == 3'h0 |-> !tp[1])
      else $error("second timer pulsed while stopped");
   AST_HOLD_HALT: assert property (quiet > 4'h2 && held |-> tp == 2'h0)
      else $error("pulse while divider reset held");
   AST_DIV8_GAP: assert property (disable iff (!aresetn || wr)
      quiet > 4'h2 && sel0 == 3'h2 && !held && tp[0] |=> !tp[0] [*7] ##1 tp[0])
      else $error("divide by eight period wrong");
   AST_RISE_LAT: assert property (quiet > 4'h2 && sel0 == 3'h7 && !held
      && $rose(ext_count_pin[0]) |-> ##[3:6] tp[0]) else $error("rising edge lost");
   AST_FALL_LAT: assert property (quiet > 4'h2 && sel1 == 3'h6 && !held
      && $fell(ext_count_pin[1]) |-> ##[3:6] tp[1]) else $error("falling edge lost");
   AST_RISE_ONLY: assert property (quiet > 4'h2 && sel0 == 3'h7
      && $fell(ext_count_pin[0]) |-> !tp[0] [*6]) else $error("pulse on wrong edge");
endmodule : timer_prescaler_sync_props
bind timer_prescaler_sync timer_prescaler_sync_props #(.NUM_TIMERS(NUM_TIMERS))
   timer_prescaler_sync_props_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .ext_count_pin,
   .timer_count_pulse);
`default_nettype wire
